/* core/sas_pkg.sv */
package sas_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int HCLK_MHZ = 125;
  localparam int STARTUP_NORMAL_US = 5;
  localparam int STARTUP_WARM_US = 1;
  localparam logic [9:0] STARTUP_NORMAL_CYC = 10'(STARTUP_NORMAL_US * HCLK_MHZ);
  localparam logic [9:0] STARTUP_WARM_CYC = 10'(STARTUP_WARM_US * HCLK_MHZ);
  // Least acquisition time software must program for the supply-over-three reference.
  localparam int VDD3_ACQ_MIN_US = 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DATA = 12'h008;
  localparam logic [11:0] OFF_CMD = 12'h00C;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_WARM_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam int CTRL_CHAN_LSB = 4;
  localparam int CTRL_ACQ_LSB = 8;
  localparam int CTRL_PRE_LSB = 16;
  localparam int CMD_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WARM_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0004_0000;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Resolutions, conversion lengths, channels
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_12 = 2'b00;
  localparam logic [1:0] RES_8 = 2'b01;
  localparam logic [1:0] RES_6 = 2'b10;
  localparam logic [3:0] BITS_12 = 4'hC;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_6 = 4'h6;
  localparam logic [3:0] CONV_CYC_12 = 4'hD;
  localparam logic [3:0] CONV_CYC_8 = 4'hB;
  localparam logic [3:0] CONV_CYC_6 = 4'h7;
  localparam logic [3:0] SAR_MSB = 4'hB;
  localparam int EXT_CHANNELS = 8;
  localparam int INT_CHANNELS = 6;
  localparam logic [3:0] LAST_CHANNEL = 4'(EXT_CHANNELS + INT_CHANNELS - 1);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WARM = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b011,
    ST_FINISH = 3'b100
  } sas_state_type;

endpackage : sas_pkg

/* core/sas_approx.sv */
`timescale 1ns/10ps
module sas_approx
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Step control
  input wire logic load,
  input wire logic step,
  input wire logic [3:0] lsb_idx,
  input wire logic comp_in,
  // Trial code to the converter core
  output logic [11:0] code
);

  logic [11:0] code_r;
  logic [11:0] code_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  wire last_step = (idx_r == lsb_idx);

  // ----------------------------------------------------------------
  // Per-bit decision
  // ----------------------------------------------------------------
  // Each step keeps the comparator verdict for the current bit; every step but the last tries the next lower one.
  for (genvar i = 0; i < 12; i++)
  begin : g_bit
    assign code_nxt[i] = load ? (4'(i) == SAR_MSB) :
                         (step && idx_r == 4'(i)) ? comp_in :
                         (step && idx_r == 4'(i + 1) && !last_step) ? 1'b1 :
                         code_r[i];
  end

  // Bit pointer walks from the top bit toward the resolution's lowest bit.
  assign idx_nxt = load ? SAR_MSB : (step && !last_step) ? 4'(idx_r - 4'h1) : idx_r;

  // Trial code and bit pointer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      code_r <= 12'h000;
      idx_r <= 4'h0;
    end
    else
    begin
      code_r <= code_nxt;
      idx_r <= idx_nxt;
    end
  end

  assign code = code_r;

endmodule : sas_approx

/* core/sas_top.sv */
// Contract
// - Result resolved one bit per step, most significant bit down to least.
// - Resolutions up to 12 bits; throughput up to one million samples per second; each start here waits at least 1 us first, so it stays below that.
// - Source chosen from eight external or six internal channels.
// - Conversion lasts 7, 11 or 13 converter clocks for 6, 8, 12 bits.
// - Acquisition holds for a programmed 1 to 256 converter clock cycles.
// - Normal mode waits about 5 us for reference and core startup.
// - Keep-warm mode, core already powered, shortens startup wait to about 1 us.
`timescale 1ns/10ps
module sas_top
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter core
  input wire logic comp_in,
  output logic converter_clock,
  output logic core_power_en,
  output logic [3:0] mux_sel,
  output logic track_en,
  output logic [11:0] dac_code,
  output logic conv_done
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [11:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic [31:0] ctrl_r;
  logic done_r;
  logic err_r;
  logic [11:0] result_r;
  logic [31:0] rd_mux;
  sas_state_type state_r;
  sas_state_type state_nxt;

  // Address phase decode; only word transfers are issued by the master.
  wire accept = hsel && htrans[1] && hready && (hsize == 3'b010);
  wire wr_ctrl = wr_pend_r && (addr_r == OFF_CTRL);
  wire wr_stat = wr_pend_r && (addr_r == OFF_STATUS);
  wire wr_cmd = wr_pend_r && (addr_r == OFF_CMD);
  wire busy = (state_r != ST_IDLE);

  // Read selection; unmapped offsets and the command register read as zero.
  assign rd_mux = (addr_r == OFF_CTRL) ? ctrl_r :
                  (addr_r == OFF_STATUS) ? {28'h000_0000, err_r, done_r, core_power_en, busy} :
                  (addr_r == OFF_DATA) ? {20'h0_0000, result_r} :
                  32'h0000_0000;

  // Reads take one wait state so the data is a registered copy of state after any prior write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 12'h000;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      addr_r <= accept ? haddr[11:0] : addr_r;
      wr_pend_r <= accept && hwrite;
      rd_pend_r <= accept && !hwrite;
      hreadyout_r <= !(accept && !hwrite);
      hresp_r <= 1'b0;
      hrdata_r <= rd_pend_r ? rd_mux : hrdata_r;
    end
  end

  // Configuration register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= hwdata;
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire keep_warm_mode = ctrl_r[CTRL_WARM_BIT];
  wire [1:0] res_sel = ctrl_r[CTRL_RES_LSB +: 2];
  wire [3:0] chan_sel = ctrl_r[CTRL_CHAN_LSB +: 4];
  wire [7:0] acq_sel = ctrl_r[CTRL_ACQ_LSB +: 8];
  wire [7:0] pre_sel = ctrl_r[CTRL_PRE_LSB +: 8];
  wire start_req = wr_cmd && hwdata[CMD_START_BIT] && !busy;
  wire chan_ok = (chan_sel <= LAST_CHANNEL);
  wire go = start_req && chan_ok;

  // Resolution chosen at start; the unused code falls back to full resolution.
  logic [1:0] res_r;
  wire [3:0] res_bits = (res_r == RES_8) ? BITS_8 : (res_r == RES_6) ? BITS_6 : BITS_12;
  wire [3:0] conv_total = (res_r == RES_8) ? CONV_CYC_8 : (res_r == RES_6) ? CONV_CYC_6 : CONV_CYC_12;
  wire [3:0] lsb_idx = 4'(BITS_12 - res_bits);

  // ----------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------
  // The converter clock period is two times (prescale plus one) hclk cycles; keep it at or below 13 MHz.
  logic [7:0] div_cnt_r;
  logic conv_clk_r;
  wire div_hit = (div_cnt_r == pre_sel);
  wire conv_tick = div_hit && !conv_clk_r;

  // Divider counter and clock phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_r <= 8'h00;
      conv_clk_r <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_hit ? 8'h00 : 8'(div_cnt_r + 8'h01);
      conv_clk_r <= div_hit ? !conv_clk_r : conv_clk_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [9:0] wcnt_r;
  logic [7:0] acnt_r;
  logic [3:0] ccnt_r;
  logic [11:0] sar_code;
  wire acq_end = (state_r == ST_ACQ) && conv_tick && (acnt_r == 8'h00);
  wire sar_step = (state_r == ST_CONV) && conv_tick && (ccnt_r <= res_bits);
  wire conv_end = (state_r == ST_CONV) && conv_tick && (ccnt_r == 4'h1);
  // A core that is still powered needs only the short startup.
  wire [9:0] wait_len = core_power_en ? STARTUP_WARM_CYC : STARTUP_NORMAL_CYC;

  // Next state.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = go ? ST_WARM : ST_IDLE;
      ST_WARM: state_nxt = (wcnt_r == 10'h000) ? ST_ACQ : ST_WARM;
      ST_ACQ: state_nxt = acq_end ? ST_CONV : ST_ACQ;
      ST_CONV: state_nxt = conv_end ? ST_FINISH : ST_CONV;
      ST_FINISH: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State and phase counters.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      wcnt_r <= 10'h000;
      acnt_r <= 8'h00;
      ccnt_r <= 4'h0;
      res_r <= RES_12;
    end
    else
    begin
      state_r <= state_nxt;
      wcnt_r <= go ? 10'(wait_len - 10'h001) : (wcnt_r != 10'h000) ? 10'(wcnt_r - 10'h001) : wcnt_r;
      acnt_r <= go ? acq_sel : (state_r == ST_ACQ && conv_tick) ? 8'(acnt_r - 8'h01) : acnt_r;
      ccnt_r <= acq_end ? conv_total : (state_r == ST_CONV && conv_tick) ? 4'(ccnt_r - 4'h1) : ccnt_r;
      res_r <= go ? res_sel : res_r;
    end
  end

  // Successive approximation register.
  sas_approx u_approx (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(acq_end),
    .step(sar_step),
    .lsb_idx(lsb_idx),
    .comp_in(comp_in),
    .code(sar_code)
  );

  // ----------------------------------------------------------------
  // Status, result and core controls
  // ----------------------------------------------------------------
  wire finish = (state_r == ST_FINISH);
  // A completion in the same cycle as its clear keeps the flag set.
  wire done_nxt = finish || (done_r && !(wr_stat && hwdata[STAT_DONE_BIT]));
  wire err_nxt = (start_req && !chan_ok) || (err_r && !(wr_stat && hwdata[STAT_ERR_BIT]));
  // Power drops after a conversion unless keep-warm mode is on.
  wire power_nxt = go || busy || (core_power_en && keep_warm_mode);

  // Flags, result and outputs to the core.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      result_r <= RESULT_RESET;
      core_power_en <= 1'b0;
      mux_sel <= 4'h0;
      track_en <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      done_r <= done_nxt;
      err_r <= err_nxt;
      result_r <= finish ? 12'(sar_code >> lsb_idx) : result_r;
      core_power_en <= power_nxt;
      mux_sel <= go ? chan_sel : mux_sel;
      track_en <= (state_nxt == ST_ACQ);
      conv_done <= finish;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign converter_clock = conv_clk_r;
  assign dac_code = sar_code;

endmodule : sas_top

/* verification/sas_top_properties.sv */
`timescale 1ns/10ps
module sas_top_properties
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  // Converter core
  input wire logic converter_clock,
  input wire logic core_power_en,
  input wire logic [3:0] mux_sel,
  input wire logic track_en,
  input wire logic [11:0] dac_code,
  input wire logic conv_done
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic cclk_r;
  logic [9:0] pwr_r;
  logic [9:0] acq_r;
  logic [4:0] conv_r;
  wire tick = converter_clock & ~cclk_r;
  // Ticks are counted on the pin, so the checks hold for any prescale.
  // The power counter restarts at each completion, so a warm start is timed from the previous result.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cclk_r <= 1'b0;
      pwr_r <= 10'h000;
      acq_r <= 10'h000;
      conv_r <= 5'h00;
    end
    else
    begin
      cclk_r <= converter_clock;
      pwr_r <= (!core_power_en || conv_done) ? 10'h000 : (pwr_r == 10'h3FF ? pwr_r : pwr_r + 10'h001);
      acq_r <= !track_en ? 10'h000 : acq_r + 10'(tick);
      conv_r <= track_en ? 5'h00 : conv_r + 5'(tick);
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_chan_range:
    assert property (track_en |-> mux_sel <= LAST_CHANNEL) else $error("channel out of range");
  a_cold_start:
    assert property ($rose(core_power_en) |-> ##[618:634] $rose(track_en)) else $error("cold startup wrong");
  a_warm_floor:
    assert property ($rose(track_en) |-> pwr_r >= 10'h07C) else $error("startup too short");
  a_msb_first:
    assert property ($fell(track_en) |-> dac_code == 12'h800) else $error("first trial not msb");
  a_acq_ticks:
    assert property ($fell(track_en) |-> acq_r <= 10'h102) else $error("acquisition too long");
  a_conv_ticks:
    assert property (conv_done |-> conv_r inside {[5'h06:5'h0F]}) else $error("conversion length wrong");
  a_done_pulse:
    assert property (conv_done |=> !conv_done && !track_en) else $error("done not a pulse");
  a_read_wait:
    assert property (hsel && htrans[1] && hready && !hwrite && hsize == 3'b010 |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
  c_done: cover property (conv_done);
  c_warm: cover property ($rose(track_en) && pwr_r < 10'h200);
  c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule : sas_top_properties

bind sas_top sas_top_properties u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hsize, .hready,
  .hreadyout, .converter_clock, .core_power_en, .mux_sel, .track_en, .dac_code, .conv_done);

/* verification/sas_core_model.sv */
`timescale 1ns/10ps
module sas_core_model
(
  // Sequencer side
  input wire logic hclk,
  input wire logic track_en,
  input wire logic [3:0] mux_sel,
  input wire logic [11:0] dac_code,
  // Analog stand-in
  input wire logic [11:0] level,
  output logic comp_in
);
  // ----------------------------------------------------------------
  // Sample and compare
  // ----------------------------------------------------------------
  logic [11:0] held_r;
  // Each channel adds its index, so a wrong channel gives a wrong result.
  always_ff @(posedge hclk)
  begin
    if (track_en)
    begin
      held_r <= level + 12'(mux_sel);
    end
  end
  // The held value stays put while the trial code walks down.
  assign comp_in = (held_r >= dac_code);
endmodule : sas_core_model

/* verification/sar_adc_sequencer_tb.sv */
`timescale 1ns/10ps
module sar_adc_sequencer_tb;
  import sas_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [11:0] level = 12'h9A5;
  logic [31:0] hrdata;
  logic hreadyout, hresp, comp_in, converter_clock, core_power_en, track_en, conv_done;
  logic [3:0] mux_sel;
  logic [11:0] dac_code;
  int miscompares = 0;
  int checks_done = 0;
  wire hready = hreadyout;
  sas_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .comp_in, .converter_clock, .core_power_en, .mux_sel, .track_en, .dac_code, .conv_done);
  sas_core_model u_core (.hclk, .track_en, .mux_sel, .dac_code, .level, .comp_in);
  // Free-running bus clock.
  initial forever #4 hclk = ~hclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task wrap_up();
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk
  // Waits on track_en (sel 0) or conv_done (sel 1); a hang ends the run.
  task wait_on(input int sel, input logic lvl, output int n);
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while ((sel == 0 ? track_en : conv_done) !== lvl && n < 3000);
    if ((sel == 0 ? track_en : conv_done) !== lvl)
    begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_on
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    for (int ph = 0; ph < 2; ph++)
    begin
      n = 0;
      do
      begin
        @(posedge hclk);
        n++;
      end
      while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1)
      begin
        miscompares++;
        wrap_up();
      end
      // Only the address phase is released; the second pass waits for hready to end the data phase before returning.
      if (ph == 0)
      begin
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
      end
    end
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : bus
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(nm, exp, x);
  endtask : rdchk
  // One full conversion, timed phase by phase and judged at the registers.
  task conv(input logic [1:0] res, input logic [3:0] ch, input logic [7:0] acq, input logic warm,
    input int start, input int cyc, input int bits);
    int n;
    wr(OFF_CTRL, {8'h00, 8'h04, acq, ch, 1'b0, res, warm});
    wr(OFF_CMD, 32'h0000_0001);
    wait_on(0, 1'b1, n);
    chk("startup", 1, 32'(n >= start - 4 && n <= start + 12));
    wait_on(0, 1'b0, n);
    chk("acquire", 1, 32'(n >= acq * 10 && n <= acq * 10 + 22));
    wait_on(1, 1'b1, n);
    chk("convert", 1, 32'(n >= (cyc - 1) * 10 && n <= cyc * 10 + 12));
    rdchk("result", OFF_DATA, 32'((12'h9A5 + 12'(ch)) >> (12 - bits)));
    rdchk("status", OFF_STATUS, {28'h000_0000, 2'b01, warm, 1'b0});
    wr(OFF_STATUS, 32'h0000_0004);
    chk("power", {31'h0000_0000, warm}, {31'h0000_0000, core_power_en});
  endtask : conv
  task t_reset();
    rdchk("ctrl", OFF_CTRL, CTRL_RESET);
    rdchk("status", OFF_STATUS, 32'h0000_0000);
    rdchk("data", OFF_DATA, 32'h0000_0000);
    rdchk("unmapped", 12'h010, 32'h0000_0000);
  endtask : t_reset
  task t_modes();
    conv(RES_12, 4'h0, 8'h00, 1'b0, 625, 13, 12);
    conv(RES_8, 4'h7, 8'hFF, 1'b0, 625, 11, 8);
    conv(RES_6, 4'hD, 8'h03, 1'b0, 625, 7, 6);
    conv(2'h3, 4'h2, 8'h01, 1'b0, 625, 13, 12);
  endtask : t_modes
  task t_bad_chan();
    wr(OFF_CTRL, 32'h0004_00E0);
    wr(OFF_CMD, 32'h0000_0001);
    rdchk("err", OFF_STATUS, 32'h0000_0008);
    chk("idle", 32'h0000_0000, {31'h0000_0000, track_en});
    wr(OFF_STATUS, 32'h0000_0008);
    rdchk("clear", OFF_STATUS, 32'h0000_0000);
  endtask : t_bad_chan
  // Twenty-five ticks of 80 ns give the 2 us that the supply-over-three reference needs.
  task t_warm();
    conv(RES_12, 4'h8, 8'h18, 1'b1, 625, 13, 12);
    conv(RES_8, 4'h3, 8'h18, 1'b1, 125, 11, 8);
  endtask : t_warm
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_bad_chan();
    t_warm();
    wrap_up();
  end
endmodule : sar_adc_sequencer_tb
